//--- logic/simd_state_save_and_csr_guard.sv
// vector register state, control/status write guard and full state save/restore
`timescale 1ns/10ps
`include "simd_state_map.svh"

// Overview of operation
// - reserved-bit write faults, register stays unchanged
// - save writes vectors and csr to image
// - restore reloads vectors and csr from image
// - save/restore also carry legacy and multimedia state
// - mask goes to image bytes 28 to 31
// - zero mask means effective 0000FFBF
// - mask zero bits reserved, one bits supported
// - vector ops mix freely with legacy ops
// - reset gives csr 1F80, init keeps state
module simd_state_save_and_csr_guard
#(
   parameter logic [31:0] STORED_MASK = `MASK_STORED_DEFAULT  // supported bits mask in image
)
(
   input  wire logic                      clock,       // 10 MHz clock
   input  wire logic                      srst,        // synchronous reset, active high
   input  wire logic                      init_pin,    // initialization pin, asynchronous
   input  wire simd_state_pkg::cmd_t      cmd,         // command from the instruction stream
   input  wire logic                      mem_rvalid,  // image read data valid
   input  wire logic [127:0]              mem_rdata,   // image read data
   output simd_state_pkg::mem_req_t       mem_req,     // image memory request
   output simd_state_pkg::status_t        status,      // completion, fault, read data
   output logic [31:0]                    csr_out      // control/status register value
);

   typedef enum {ST_IDLE, ST_SAVE, ST_RD_REQ, ST_RD_WAIT} state_t;

   state_t        state_r;
   logic [4:0]    line_r;
   logic [4:0]    step_r;
   logic [127:0]  vec_r [8];
   logic [79:0]   fp_data_r [8];
   logic [15:0]   fp_ctrl_r;
   logic [15:0]   fp_stat_r;
   logic [15:0]   fp_tag_r;
   logic [31:0]   csr_r;
   logic          init_s1_r;
   logic          init_s2_r;
   logic          init_d_r;
   logic          init_evt;
   logic [31:0]   check_val;
   logic [31:0]   eff_mask;
   logic          reserved_hit;
   logic          cmd_take;

   ////////////////////////////////////////////////////////////////////////////////
   // image line layout
   function automatic logic [4:0] restore_line(input logic [4:0] step);
      // csr line is fetched first so a fault can stop the restore untouched
      if (step == 5'h00)
         restore_line = `LINE_CSR_MASK;
      else if (step == 5'h01)
         restore_line = `LINE_LEGACY_CTRL;
      else
         restore_line = step;
   endfunction

   function automatic logic [127:0] save_line(input logic [4:0] line);
      logic [127:0] d;
      d = '0;
      if (line == `LINE_LEGACY_CTRL)
      begin
         d[15:0] = fp_ctrl_r;
         d[`FP_STAT_LSB +: 16] = fp_stat_r;
         d[`FP_TAG_LSB +: 16] = fp_tag_r;
      end
      else if (line == `LINE_CSR_MASK)
      begin
         d[`CSR_LSB +: 32] = csr_r;
         d[`MASK_LSB +: 32] = STORED_MASK;
      end
      else if (line < `LINE_VEC_BASE)
         d[79:0] = fp_data_r[3'(line - `LINE_FP_BASE)];
      else if (line <= `LINE_VEC_LAST)
         d = vec_r[3'(line - `LINE_VEC_BASE)];
      save_line = d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // initialization pin synchroniser
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         init_s1_r <= 1'b0;
         init_s2_r <= 1'b0;
         init_d_r  <= 1'b0;
      end
      else
      begin
         init_s1_r <= init_pin;
         init_s2_r <= init_s1_r;
         init_d_r  <= init_s2_r;
      end
   end

   assign init_evt = init_s2_r & ~init_d_r;
   assign cmd_take = cmd.valid && (state_r == ST_IDLE) && !init_evt;

   ////////////////////////////////////////////////////////////////////////////////
   // reserved-bit guard, shared by load and restore
   assign check_val = (state_r == ST_RD_WAIT) ? mem_rdata[`CSR_LSB +: 32] : cmd.data[31:0];

   csr_write_check u_check
   (
      .value        (check_val),
      .stored_mask  (STORED_MASK),
      .eff_mask     (eff_mask),
      .reserved_hit (reserved_hit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r <= ST_IDLE;
         line_r  <= 5'h00;
         step_r  <= 5'h00;
      end
      else if (init_evt)
         state_r <= ST_IDLE;
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               line_r <= 5'h00;
               step_r <= 5'h00;
               if (cmd_take && cmd.op == simd_state_pkg::OP_SAVE)
                  state_r <= ST_SAVE;
               else if (cmd_take && cmd.op == simd_state_pkg::OP_RESTORE)
                  state_r <= ST_RD_REQ;
            end
            ST_SAVE:
            begin
               line_r <= line_r + 5'h01;
               if (line_r == `IMAGE_LAST_LINE)
                  state_r <= ST_IDLE;
            end
            ST_RD_REQ:
               state_r <= ST_RD_WAIT;
            ST_RD_WAIT:
               if (mem_rvalid)
               begin
                  step_r <= step_r + 5'h01;
                  if ((step_r == 5'h00 && reserved_hit) || step_r == `LINE_VEC_LAST)
                     state_r <= ST_IDLE;
                  else
                     state_r <= ST_RD_REQ;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control/status register
   always_ff @(posedge clock)
   begin
      if (srst)
         csr_r <= `CSR_RESET_VALUE;
      else if (cmd_take && cmd.op == simd_state_pkg::OP_CSR_LOAD && !reserved_hit)
         csr_r <= cmd.data[31:0];
      // an init abort drops the answer that arrives in the same cycle
      else if (state_r == ST_RD_WAIT && mem_rvalid && !init_evt && step_r == 5'h00
               && !reserved_hit)
         csr_r <= mem_rdata[`CSR_LSB +: 32];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // vector registers: independent of legacy traffic, so any interleaving works
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         for (int i = 0; i < 8; i++)
            vec_r[i] <= '0;
      end
      else if (cmd_take && cmd.op == simd_state_pkg::OP_VEC_WRITE)
         vec_r[cmd.idx] <= cmd.data;
      else if (state_r == ST_RD_WAIT && mem_rvalid && !init_evt && step_r >= `LINE_VEC_BASE)
         vec_r[3'(step_r - `LINE_VEC_BASE)] <= mem_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // legacy and aliased multimedia state
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         fp_ctrl_r <= `FP_CTRL_RESET_VALUE;
         fp_stat_r <= `FP_STAT_RESET_VALUE;
         fp_tag_r  <= `FP_TAG_RESET_VALUE;
         for (int i = 0; i < 8; i++)
            fp_data_r[i] <= '0;
      end
      else if (cmd_take)
      begin
         unique case (cmd.op)
            simd_state_pkg::OP_FP_WRITE:
               fp_data_r[cmd.idx] <= cmd.data[79:0];
            simd_state_pkg::OP_MM_WRITE:
            begin
               // multimedia registers alias the low 64 bits of the data registers
               fp_data_r[cmd.idx] <= {`MM_EXP_FILL_VALUE, cmd.data[63:0]};
               fp_tag_r <= 16'h0000;
            end
            simd_state_pkg::OP_MM_EMPTY:
               fp_tag_r <= `FP_TAG_EMPTY_VALUE;
            default:
               fp_tag_r <= fp_tag_r;
         endcase
      end
      else if (state_r == ST_RD_WAIT && mem_rvalid && !init_evt && step_r == 5'h01)
      begin
         fp_ctrl_r <= mem_rdata[15:0];
         fp_stat_r <= mem_rdata[`FP_STAT_LSB +: 16];
         fp_tag_r  <= mem_rdata[`FP_TAG_LSB +: 16];
      end
      else if (state_r == ST_RD_WAIT && mem_rvalid && !init_evt && step_r >= `LINE_FP_BASE
               && step_r < `LINE_VEC_BASE)
         fp_data_r[3'(step_r - `LINE_FP_BASE)] <= mem_rdata[79:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // image memory port
   always_ff @(posedge clock)
   begin
      if (srst || init_evt)
         mem_req <= '0;
      else
      begin
         mem_req.wr    <= (state_r == ST_SAVE);
         mem_req.rd    <= (state_r == ST_RD_REQ);
         mem_req.addr  <= (state_r == ST_SAVE) ? line_r : restore_line(step_r);
         mem_req.wdata <= (state_r == ST_SAVE) ? save_line(line_r) : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status and read back
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         status  <= '0;
         csr_out <= `CSR_RESET_VALUE;
      end
      else
      begin
         csr_out      <= csr_r;
         status.busy  <= (state_r != ST_IDLE) || cmd_take &&
                         (cmd.op == simd_state_pkg::OP_SAVE || cmd.op == simd_state_pkg::OP_RESTORE);
         status.fault <= (cmd_take && cmd.op == simd_state_pkg::OP_CSR_LOAD && reserved_hit) ||
                         (state_r == ST_RD_WAIT && mem_rvalid && step_r == 5'h00 && reserved_hit);
         status.done  <= (cmd_take && cmd.op != simd_state_pkg::OP_SAVE &&
                          cmd.op != simd_state_pkg::OP_RESTORE) ||
                         (state_r == ST_SAVE && line_r == `IMAGE_LAST_LINE) ||
                         (state_r == ST_RD_WAIT && mem_rvalid &&
                          ((step_r == 5'h00 && reserved_hit) || step_r == `LINE_VEC_LAST));
         if (cmd_take && cmd.op == simd_state_pkg::OP_READ_VEC)
            status.rd_data <= vec_r[cmd.idx];
         else if (cmd_take && cmd.op == simd_state_pkg::OP_CSR_LOAD)
            status.rd_data <= {96'h0, eff_mask};
      end
   end

endmodule // simd_state_save_and_csr_guard

//--- inc/simd_state_map.svh
// offsets, field positions, reset values and counts of the vector state save block
`ifndef SIMD_STATE_MAP_SVH
`define SIMD_STATE_MAP_SVH

`define CSR_RESET_VALUE      32'h0000_1f80
`define MASK_DEFAULT_VALUE   32'h0000_ffbf
`define MASK_STORED_DEFAULT  32'h0000_ffff
`define FP_CTRL_RESET_VALUE  16'h0000
`define FP_STAT_RESET_VALUE  16'h0000
`define FP_TAG_RESET_VALUE   16'h0000
`define FP_TAG_EMPTY_VALUE   16'hffff
`define MM_EXP_FILL_VALUE    16'hffff
`define IMAGE_LINES          6'h20
`define IMAGE_LAST_LINE      5'h1f
`define LINE_LEGACY_CTRL     5'h00
`define LINE_CSR_MASK        5'h01
`define LINE_FP_BASE         5'h02
`define LINE_VEC_BASE        5'h0a
`define LINE_VEC_LAST        5'h11
`define CSR_LSB              64
`define MASK_LSB             96
`define FP_STAT_LSB          16
`define FP_TAG_LSB           32

`endif

//--- inc/simd_state_pkg.sv
// types shared by the vector state save block
package simd_state_pkg;

   typedef enum logic [2:0]
   {
      OP_VEC_WRITE,
      OP_MM_WRITE,
      OP_FP_WRITE,
      OP_CSR_LOAD,
      OP_MM_EMPTY,
      OP_READ_VEC,
      OP_SAVE,
      OP_RESTORE
   } op_t;

   typedef struct packed
   {
      logic         valid;
      op_t          op;
      logic [2:0]   idx;
      logic [127:0] data;
   } cmd_t;

   typedef struct packed
   {
      logic         wr;
      logic         rd;
      logic [4:0]   addr;
      logic [127:0] wdata;
   } mem_req_t;

   typedef struct packed
   {
      logic         done;
      logic         fault;
      logic         busy;
      logic [127:0] rd_data;
   } status_t;

endpackage

//--- logic/csr_write_check.sv
// reserved-bit check of a value bound for the vector control/status register
`timescale 1ns/10ps
`include "simd_state_map.svh"

module csr_write_check
(
   input  wire logic [31:0] value,        // value about to be written
   input  wire logic [31:0] stored_mask,  // mask as stored in the save image
   output logic      [31:0] eff_mask,     // effective supported-bits mask
   output logic             reserved_hit  // a 1 lands on a reserved bit
);

   always_comb
   begin
      eff_mask = (stored_mask == 32'h0000_0000) ? `MASK_DEFAULT_VALUE : stored_mask;
      reserved_hit = |(value & ~eff_mask);
   end

endmodule // csr_write_check

//--- bench/simd_state_save_and_csr_guard_chk.sv
// port assertions of the vector state save block
`timescale 1ns/10ps
module simd_state_save_and_csr_guard_chk
#(
   parameter logic [31:0] STORED_MASK = 32'h0000_ffff  // mask stored in image
)
(
   input wire logic                     clock,       // clock
   input wire logic                     srst,        // reset
   input wire logic                     init_pin,    // init pin
   input wire simd_state_pkg::cmd_t     cmd,         // command
   input wire logic                     mem_rvalid,  // read valid
   input wire logic [127:0]             mem_rdata,   // read data
   input wire simd_state_pkg::mem_req_t mem_req,     // memory request
   input wire simd_state_pkg::status_t  status,      // status
   input wire logic [31:0]              csr_out      // csr value
);
   localparam logic [31:0] EFF = (STORED_MASK == 32'h0000_0000) ? 32'h0000_ffbf : STORED_MASK;
   logic ld;
   logic bad;
   logic sv;
   logic rs;
   assign ld  = cmd.valid && !status.busy && cmd.op == simd_state_pkg::OP_CSR_LOAD;
   assign sv  = cmd.valid && !status.busy && cmd.op == simd_state_pkg::OP_SAVE;
   assign rs  = cmd.valid && !status.busy && cmd.op == simd_state_pkg::OP_RESTORE;
   assign bad = (cmd.data[31:0] & ~EFF) != 32'h0000_0000;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////
   a_csr_reset_value: assert property ($fell(srst) |-> csr_out == 32'h0000_1f80)
      else $error("csr not at reset value");
   a_fault_on_reserved: assert property (ld && bad |=> status.fault && status.done)
      else $error("reserved write without fault");
   a_fault_keeps_csr: assert property (status.fault |=> $stable(csr_out))
      else $error("csr changed on fault");
   a_legal_load_taken: assert property (ld && !bad |=> status.done && !status.fault
      ##1 csr_out == $past(cmd.data[31:0], 2)) else $error("legal load not taken");
   a_load_gives_mask: assert property (ld |=> status.rd_data[31:0] == EFF)
      else $error("wrong effective mask");
   a_save_walk: assert property (sv |=> ##1 mem_req.wr && mem_req.addr == 5'h00
      ##31 mem_req.wr && mem_req.addr == 5'h1f && status.done ##1 !mem_req.wr)
      else $error("save line walk wrong");
   a_mask_in_image: assert property (mem_req.wr && mem_req.addr == 5'h01
      |-> mem_req.wdata[127:96] == STORED_MASK) else $error("mask field wrong");
   a_idle_no_memory: assert property (!status.busy |-> !mem_req.wr && !mem_req.rd)
      else $error("memory access while idle");
   a_restore_csr_first: assert property (rs |=> ##1 mem_req.rd && mem_req.addr == 5'h01)
      else $error("restore does not read csr line first");
   a_init_keeps_csr: assert property ($rose(init_pin) && !cmd.valid && !status.done
      |=> $stable(csr_out) [*4]) else $error("init changed csr");
endmodule // simd_state_save_and_csr_guard_chk

//--- bench/simd_state_save_and_csr_guard_tb.sv
// self-checking bench of the vector state save block
`timescale 1ns/10ps
module simd_state_save_and_csr_guard_tb;
   localparam logic [31:0]  SMASK = 32'h0000_0000;
   localparam logic [31:0]  EFF   = (SMASK == 32'h0000_0000) ? 32'h0000_ffbf : SMASK;
   localparam logic [127:0] V0    = {4{32'h1357_9bdf}};
   localparam logic [127:0] V3    = {4{32'h0246_8ace}};
   localparam logic [127:0] V5    = {4{32'hdead_0005}};
   localparam logic [127:0] F1    = {4{32'h3ff0_1111}};
   localparam logic [127:0] M2    = {4{32'h7777_2222}};
   logic                     clock = 1'b0;
   logic                     srst = 1'b1;
   logic                     init_pin = 1'b0;
   simd_state_pkg::cmd_t     cmd = '0;
   logic                     mem_rvalid = 1'b0;
   logic [127:0]             mem_rdata = '0;
   simd_state_pkg::mem_req_t mem_req;
   simd_state_pkg::status_t  status;
   logic [31:0]              csr_out;
   logic [127:0]             image [0:31];
   logic [127:0]             rd;
   logic                     flt;
   int                       n_fail = 0;
   int                       checks = 0;

   always #50 clock = ~clock;

   simd_state_save_and_csr_guard #(.STORED_MASK(SMASK)) simd_state_save_and_csr_guard_i
   (
      .clock(clock), .srst(srst), .init_pin(init_pin), .cmd(cmd), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .mem_req(mem_req), .status(status), .csr_out(csr_out)
   );

   ////////////////////////////////////////////////////////////////
   // image memory: keeps written lines, answers a read one cycle later
   always @(posedge clock)
      if (mem_req.wr)
         image[mem_req.addr] <= mem_req.wdata;

   always @(negedge clock)
   begin
      mem_rvalid <= mem_req.rd;
      mem_rdata  <= mem_req.rd ? image[mem_req.addr] : ~mem_rdata;
   end

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic do_op(input simd_state_pkg::op_t op, input logic [2:0] idx,
                        input logic [127:0] data);
      int n;
      @(negedge clock);
      cmd <= '{1'b1, op, idx, data};
      @(negedge clock);
      cmd.valid <= 1'b0;
      for (n = 0; n < 200 && status.done !== 1'b1; n++)
         @(negedge clock);
      if (n == 200)
      begin
         n_fail++;
         tally_and_finish();
      end
      rd  = status.rd_data;
      flt = status.fault;
      repeat (2) @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_csr();
      logic [31:0] vals [4] = '{32'h0000_ffbf, 32'h0000_0040, 32'h0001_0000, 32'h0000_1f80};
      logic [31:0] exp = 32'h0000_1f80;
      logic        f;
      check(csr_out, 32'h0000_1f80);
      do_op(simd_state_pkg::OP_READ_VEC, 3'h0, '0);
      check(rd, '0);
      do_op(simd_state_pkg::OP_CSR_LOAD, 3'h0, {96'h0, 32'hffff_ffff & EFF});
      check(flt, 1'b0);
      check(csr_out, EFF);
      foreach (vals[i])
      begin
         f = (vals[i] & ~EFF) != 32'h0000_0000;
         if (!f)
            exp = vals[i];
         do_op(simd_state_pkg::OP_CSR_LOAD, 3'h0, {96'h0, vals[i]});
         check(flt, f);
         check(rd[31:0], EFF);
         check(csr_out, exp);
      end
      $display("test csr load finished");
   endtask

   task automatic t_mix_save();
      do_op(simd_state_pkg::OP_VEC_WRITE, 3'h3, V3);
      do_op(simd_state_pkg::OP_FP_WRITE, 3'h1, F1);
      do_op(simd_state_pkg::OP_VEC_WRITE, 3'h5, V5);
      do_op(simd_state_pkg::OP_SAVE, 3'h0, '0);
      do_op(simd_state_pkg::OP_MM_WRITE, 3'h2, M2);
      do_op(simd_state_pkg::OP_MM_EMPTY, 3'h0, '0);
      do_op(simd_state_pkg::OP_READ_VEC, 3'h3, '0);
      check(rd, V3);
      do_op(simd_state_pkg::OP_SAVE, 3'h0, '0);
      check(image[1][95:64], 32'h0000_1f80);
      check(image[1][127:96], SMASK);
      check(image[13], V3);
      check(image[15], V5);
      check(image[3][79:0], F1[79:0]);
      check(image[4][79:0], {16'hffff, M2[63:0]});
      check(image[0][47:32], 16'hffff);
      $display("test mixed ops and save finished");
   endtask

   task automatic t_restore();
      image[10] = V0;
      image[1][95:64] = 32'h0000_3f80;
      do_op(simd_state_pkg::OP_RESTORE, 3'h0, '0);
      check(flt, 1'b0);
      check(csr_out, 32'h0000_3f80);
      image[10] = ~V0;
      image[1][95:64] = 32'h0000_0040;
      do_op(simd_state_pkg::OP_RESTORE, 3'h0, '0);
      check(flt, 1'b1);
      check(csr_out, 32'h0000_3f80);
      do_op(simd_state_pkg::OP_READ_VEC, 3'h0, '0);
      check(rd, V0);
      $display("test restore finished");
   endtask

   task automatic t_init();
      init_pin <= 1'b1;
      repeat (3) @(negedge clock);
      init_pin <= 1'b0;
      repeat (6) @(negedge clock);
      // a restore cut short by the init pin must not reach the vector lines
      image[1][95:64] = 32'h0000_3f80;
      image[10] = V3;
      cmd <= '{1'b1, simd_state_pkg::OP_RESTORE, 3'h0, 128'h0};
      init_pin <= 1'b1;
      @(negedge clock);
      cmd.valid <= 1'b0;
      check(status.busy, 1'b1);
      repeat (3) @(negedge clock);
      init_pin <= 1'b0;
      repeat (30) @(negedge clock);
      check(status.busy, 1'b0);
      check(csr_out, 32'h0000_3f80);
      do_op(simd_state_pkg::OP_READ_VEC, 3'h0, '0);
      check(rd, V0);
      $display("test init pin finished");
   endtask

   initial
   begin
      repeat (6) @(negedge clock);
      srst <= 1'b0;
      t_csr();
      t_mix_save();
      t_restore();
      t_init();
      tally_and_finish();
   end
endmodule // simd_state_save_and_csr_guard_tb

bind simd_state_save_and_csr_guard simd_state_save_and_csr_guard_chk
   #(.STORED_MASK(STORED_MASK)) chk_i
   (
      .clock(clock), .srst(srst), .init_pin(init_pin), .cmd(cmd), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .mem_req(mem_req), .status(status), .csr_out(csr_out)
   );
